/* File: rtl/audio_decoder_control_status_regs.sv */
// control and status register slice of the audio decoder
`include "audio_regs_params.svh"
module audio_decoder_control_status_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        crystal_input_clock,
  input  wire logic        data_request,
  input  wire logic        decoder_in_decode,
  input  wire logic [1:0]  sync_state_in,
  input  wire logic        frame_locked,
  input  wire logic [20:0] frame_header_in,
  input  wire logic        frame_decoded_ok,
  input  wire logic [15:0] anc_bit_count_in,
  input  wire logic [39:0] anc_data_in,
  output logic             play_active,
  output logic             mute_active,
  output logic             output_clock_enable,
  output logic             request_pin,
  output logic             soft_reset_pulse,
  output logic             anc_capture_pulse,
  output logic             core_command_clear,
  output logic [1:0]       header_version,
  output logic [1:0]       header_layer,
  output logic             header_no_crc,
  output logic [3:0]       header_bitrate_index,
  output logic             header_free_format,
  output logic             header_bitrate_bad,
  output logic [1:0]       header_sampling_index,
  output logic             header_sampling_bad,
  output logic             header_padding,
  output logic             header_private,
  output logic [1:0]       header_mode,
  output logic [1:0]       header_mode_ext,
  output logic             header_copyright,
  output logic             header_original,
  output logic [1:0]       header_emphasis,
  output logic             header_layer_ok
);
  logic [7:0]  play_control;
  logic [7:0]  mute_control;
  logic [7:0]  ancillary_capture_command;
  logic [7:0]  request_pin_select;
  logic [1:0]  sync_state;
  logic [15:0] anc_count;
  logic [20:0] frame_header;
  logic [7:0]  anc_buffer [0:`ANC_BUFFER_BYTES-1];
  logic [1:0]  xti_sync;
  logic [1:0]  req_sync;
  logic        wr_soft;
  logic        wr_capture;
  logic [7:0]  next_rdata;
  logic [7:0]  anc_index;
  integer      i;

  // write strobes decoded from the address
  assign wr_soft    = reg_write && (reg_addr == `SOFT_RESET_ADDR);
  assign wr_capture = reg_write && (reg_addr == `ANC_CAPTURE_ADDR)
                      && (reg_wdata != 8'h00);
  assign anc_index  = reg_addr - `ANC_BUFFER_FIRST_ADDR;

  // play register, soft reset returns it to its reset value
  always_ff @(posedge clk) begin
    if (!reset_n || wr_soft) begin
      play_control <= `PLAY_CONTROL_RESET;
    end else if (reg_write && reg_addr == `PLAY_CONTROL_ADDR) begin
      play_control <= reg_wdata;
    end
  end

  // mute register
  always_ff @(posedge clk) begin
    if (!reset_n || wr_soft) begin
      mute_control <= `MUTE_CONTROL_RESET;
    end else if (reg_write && reg_addr == `MUTE_CONTROL_ADDR) begin
      mute_control <= reg_wdata;
    end
  end

  // capture command register, cleared by soft reset
  always_ff @(posedge clk) begin
    if (!reset_n || wr_soft) begin
      ancillary_capture_command <= `ANC_CAPTURE_RESET;
    end else if (reg_write && reg_addr == `ANC_CAPTURE_ADDR) begin
      ancillary_capture_command <= reg_wdata;
    end
  end

  // pin function select, only bit 2 matters
  always_ff @(posedge clk) begin
    if (!reset_n || wr_soft) begin
      request_pin_select <= `REQ_PIN_SELECT_RESET;
    end else if (reg_write && reg_addr == `REQ_PIN_SELECT_ADDR) begin
      request_pin_select <= reg_wdata & 8'h04;
    end
  end

  // ancillary buffer loads on a non-zero capture command
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (i = 0; i < `ANC_BUFFER_BYTES; i = i + 1) begin
        anc_buffer[i] <= 8'h00;
      end
    end else if (wr_capture) begin
      for (i = 0; i < `ANC_BUFFER_BYTES; i = i + 1) begin
        anc_buffer[i] <= anc_data_in[i*8 +: 8];
      end
    end
  end

  // status captured from the core; the only bus write that reaches it is a soft reset, which clears it
  always_ff @(posedge clk) begin
    if (!reset_n || wr_soft) begin
      sync_state <= 2'h0;
    end else if (sync_state_in != 2'h3) begin
      sync_state <= sync_state_in;
    end
  end

  // ancillary bit count per good frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      anc_count <= 16'h0000;
    end else if (frame_decoded_ok) begin
      anc_count <= anc_bit_count_in;
    end
  end

  // header copy refreshed at each frame lock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_header <= 21'h00000;
    end else if (frame_locked) begin
      frame_header <= frame_header_in;
    end
  end

  // read multiplexer, unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PLAY_CONTROL_ADDR:   next_rdata = play_control;
      `MUTE_CONTROL_ADDR:   next_rdata = mute_control;
      `ANC_CAPTURE_ADDR:    next_rdata = ancillary_capture_command;
      `REQ_PIN_SELECT_ADDR: next_rdata = request_pin_select;
      `SYNC_STATE_ADDR:     next_rdata = {6'h00, sync_state};
      `ANC_COUNT_LOW_ADDR:  next_rdata = anc_count[7:0];
      `ANC_COUNT_HIGH_ADDR: next_rdata = anc_count[15:8];
      `HEADER_UPPER_ADDR:   next_rdata = {3'h0, frame_header[20:16]};
      `HEADER_MIDDLE_ADDR:  next_rdata = frame_header[15:8];
      `HEADER_LOWER_ADDR:   next_rdata = frame_header[7:0];
      default: begin
        if (reg_addr >= `ANC_BUFFER_FIRST_ADDR &&
            reg_addr <= `ANC_BUFFER_LAST_ADDR) begin
          next_rdata = anc_buffer[anc_index[2:0]];
        end
      end
    endcase
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // crystal clock brought into the clock domain, two stages
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      xti_sync <= 2'h0;
    end else begin
      xti_sync <= {xti_sync[0], crystal_input_clock};
    end
  end

  // data request pin brought into the clock domain, two stages
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_sync <= 2'h0;
    end else begin
      req_sync <= {req_sync[0], data_request};
    end
  end

  // shared pin follows clock copy or data request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      request_pin <= 1'b0;
    end else if (request_pin_select[`REQ_PIN_SELECT_BIT]) begin
      request_pin <= req_sync[1];
    end else begin
      request_pin <= xti_sync[1];
    end
  end

  // play request reaches the core only in decode state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      play_active <= 1'b0;
    end else begin
      play_active <= play_control[0] && decoder_in_decode;
    end
  end

  // mute flag towards the core
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mute_active <= 1'b0;
    end else begin
      mute_active <= mute_control[0];
    end
  end

  // output clock kept running while muted, so the dac stays locked
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      output_clock_enable <= 1'b0;
    end else begin
      output_clock_enable <= mute_control[0] || play_control[0];
    end
  end

  // one-cycle soft reset strobes, core returns to idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      soft_reset_pulse   <= 1'b0;
      core_command_clear <= 1'b0;
    end else begin
      soft_reset_pulse   <= wr_soft;
      core_command_clear <= wr_soft;
    end
  end

  // one-cycle strobe after a fresh capture command
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      anc_capture_pulse <= 1'b0;
    end else begin
      anc_capture_pulse <= wr_capture;
    end
  end

  // raw header fields passed on to the core
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      header_version        <= 2'h0;
      header_layer          <= 2'h0;
      header_no_crc         <= 1'b0;
      header_bitrate_index  <= 4'h0;
      header_sampling_index <= 2'h0;
      header_padding        <= 1'b0;
      header_private        <= 1'b0;
      header_mode           <= 2'h0;
      header_copyright      <= 1'b0;
      header_original       <= 1'b0;
      header_emphasis       <= 2'h0;
    end else begin
      header_version <= {frame_header[`HEAD_VERSION_EXT_BIT],
                         frame_header[`HEAD_VERSION_BIT]};
      header_layer   <= frame_header[`HEAD_LAYER_MSB:`HEAD_LAYER_LSB];
      header_no_crc  <= frame_header[`HEAD_PROTECTION_BIT];
      header_bitrate_index <=
        frame_header[`HEAD_BITRATE_MSB:`HEAD_BITRATE_LSB];
      header_sampling_index <=
        frame_header[`HEAD_SAMPLING_MSB:`HEAD_SAMPLING_LSB];
      header_padding  <= frame_header[`HEAD_PADDING_BIT];
      header_private  <= frame_header[`HEAD_PRIVATE_BIT];
      header_mode     <= frame_header[`HEAD_MODE_MSB:`HEAD_MODE_LSB];
      header_copyright <= frame_header[`HEAD_COPYRIGHT_BIT];
      header_original  <= frame_header[`HEAD_ORIGINAL_BIT];
      header_emphasis  <=
        frame_header[`HEAD_EMPHASIS_MSB:`HEAD_EMPHASIS_LSB];
    end
  end

  // layer field checked against the only legal code
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      header_layer_ok <= 1'b0;
    end else begin
      header_layer_ok <= frame_header[`HEAD_LAYER_MSB:`HEAD_LAYER_LSB]
                         == 2'h1;
    end
  end

  // free, forbidden and reserved code flags
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      header_free_format  <= 1'b0;
      header_bitrate_bad  <= 1'b0;
      header_sampling_bad <= 1'b0;
    end else begin
      header_free_format <=
        frame_header[`HEAD_BITRATE_MSB:`HEAD_BITRATE_LSB] == 4'h0;
      header_bitrate_bad <=
        frame_header[`HEAD_BITRATE_MSB:`HEAD_BITRATE_LSB] == 4'hf;
      header_sampling_bad <=
        (frame_header[`HEAD_SAMPLING_MSB:`HEAD_SAMPLING_LSB] == 2'h3) ||
        ({frame_header[`HEAD_VERSION_EXT_BIT],
          frame_header[`HEAD_VERSION_BIT]} ==
         audio_regs_pkg::version_reserved);
    end
  end

  // mode extension only carried in joint stereo
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      header_mode_ext <= 2'h0;
    end else if (frame_header[`HEAD_MODE_MSB:`HEAD_MODE_LSB] ==
                 audio_regs_pkg::mode_joint) begin
      header_mode_ext <=
        frame_header[`HEAD_MODE_EXT_MSB:`HEAD_MODE_EXT_LSB];
    end else begin
      header_mode_ext <= 2'h0;
    end
  end
endmodule

/* File: rtl/audio_regs_params.svh */
// register offsets, reset values and field positions of the register slice
`ifndef AUDIO_REGS_PARAMS_SVH
`define AUDIO_REGS_PARAMS_SVH
`define SOFT_RESET_ADDR        8'h10
`define PLAY_CONTROL_ADDR      8'h13
`define MUTE_CONTROL_ADDR      8'h14
`define ANC_CAPTURE_ADDR       8'h16
`define REQ_PIN_SELECT_ADDR    8'h18
`define SYNC_STATE_ADDR        8'h40
`define ANC_COUNT_LOW_ADDR     8'h41
`define ANC_COUNT_HIGH_ADDR    8'h42
`define HEADER_UPPER_ADDR      8'h43
`define HEADER_MIDDLE_ADDR     8'h44
`define HEADER_LOWER_ADDR      8'h45
`define ANC_BUFFER_FIRST_ADDR  8'h59
`define ANC_BUFFER_LAST_ADDR   8'h5d
`define PLAY_CONTROL_RESET     8'h01
`define MUTE_CONTROL_RESET     8'h00
`define ANC_CAPTURE_RESET      8'h00
`define REQ_PIN_SELECT_RESET   8'h00
`define REQ_PIN_SELECT_BIT     2
`define ANC_BUFFER_BYTES       5
`define HEAD_BITRATE_MSB       15
`define HEAD_BITRATE_LSB       12
`define HEAD_PROTECTION_BIT    16
`define HEAD_LAYER_MSB         18
`define HEAD_LAYER_LSB         17
`define HEAD_VERSION_BIT       19
`define HEAD_VERSION_EXT_BIT   20
`define HEAD_SAMPLING_MSB      11
`define HEAD_SAMPLING_LSB      10
`define HEAD_PADDING_BIT       9
`define HEAD_PRIVATE_BIT       8
`define HEAD_MODE_MSB          7
`define HEAD_MODE_LSB          6
`define HEAD_MODE_EXT_MSB      5
`define HEAD_MODE_EXT_LSB      4
`define HEAD_COPYRIGHT_BIT     3
`define HEAD_ORIGINAL_BIT      2
`define HEAD_EMPHASIS_MSB      1
`define HEAD_EMPHASIS_LSB      0
`endif

/* File: rtl/audio_regs_pkg.sv */
// types shared by the register slice
package audio_regs_pkg;
  typedef enum logic [1:0] {
    sync_searching = 2'h0,
    sync_waiting   = 2'h1,
    sync_locked    = 2'h2
  } sync_state_t;
  typedef enum logic [1:0] {
    version_2_5      = 2'h0,
    version_reserved = 2'h1,
    version_2        = 2'h2,
    version_1        = 2'h3
  } version_t;
  typedef enum logic [1:0] {
    mode_stereo = 2'h0,
    mode_joint  = 2'h1,
    mode_dual   = 2'h2,
    mode_single = 2'h3
  } channel_mode_t;
  typedef enum logic [1:0] {
    emph_none     = 2'h0,
    emph_50_15    = 2'h1,
    emph_reserved = 2'h2,
    emph_phone    = 2'h3
  } emphasis_t;
endpackage

/* File: test/audio_regs_checker.sv */
// port assertions for the audio decoder register slice
module audio_regs_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        decoder_in_decode,
  input wire logic        frame_locked,
  input wire logic [20:0] frame_header_in,
  input wire logic        play_active,
  input wire logic        mute_active,
  input wire logic        output_clock_enable,
  input wire logic        soft_reset_pulse,
  input wire logic        core_command_clear,
  input wire logic        anc_capture_pulse,
  input wire logic [1:0]  header_version,
  input wire logic [1:0]  header_layer,
  input wire logic [3:0]  header_bitrate_index,
  input wire logic        header_free_format,
  input wire logic [1:0]  header_sampling_index,
  input wire logic        header_sampling_bad,
  input wire logic [1:0]  header_mode,
  input wire logic [1:0]  header_mode_ext,
  input wire logic        header_layer_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, synchronous active-low reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_capture_pulse: assert property (
    reg_write && reg_addr == 8'h16 && reg_wdata != 8'h00 |=> anc_capture_pulse)
    else $error("no capture pulse after non-zero command");
  a_soft_reset_pulse: assert property (
    reg_write && reg_addr == 8'h10 |=> soft_reset_pulse && core_command_clear)
    else $error("no soft reset pulse");
  a_play_needs_decode: assert property (
    play_active |-> $past(decoder_in_decode))
    else $error("play active outside decode state");
  a_mute_keeps_clock: assert property (
    mute_active |-> output_clock_enable)
    else $error("output clock stopped while muted");
  a_layer_flag: assert property (
    header_layer_ok == (header_layer == 2'h1))
    else $error("layer flag wrong");
  a_mode_ext_gated: assert property (
    header_mode != 2'h1 |-> header_mode_ext == 2'h0)
    else $error("mode extension outside joint stereo");
  a_header_bitrate: assert property (
    frame_locked |-> ##2 header_bitrate_index ==
      $past(frame_header_in[15:12], 2) &&
      header_free_format == (header_bitrate_index == 4'h0))
    else $error("bitrate field not loaded at frame lock");
  a_sampling_bad: assert property (
    header_sampling_bad == (header_sampling_index == 2'h3 ||
      header_version == 2'h1))
    else $error("reserved sampling flag wrong");
  // main scenarios reached
  cover property (anc_capture_pulse);
  cover property (soft_reset_pulse);
  cover property ($rose(play_active));
endmodule

/* File: test/host_model.sv */
// host controller model driving register strobes
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // single write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~v;
  endtask
  // single read strobe, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // fresh capture command, then the five buffer bytes
  task automatic fetch(output logic [39:0] b);
    logic [7:0] v;
    wr(8'h16, 8'h01);
    for (int i = 0; i < 5; i++) begin
      rd(8'h59 + 8'(i), v);
      b[i*8 +: 8] = v;
    end
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the register slice
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, reg_write, reg_read, crystal_input_clock, data_request;
  logic decoder_in_decode, frame_locked, frame_decoded_ok, play_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0] sync_state_in, header_version, header_layer;
  logic [1:0] xdiv = 2'h0;
  logic [1:0] header_sampling_index, header_mode, header_mode_ext;
  logic [1:0] header_emphasis;
  logic [3:0] header_bitrate_index;
  logic [15:0] anc_bit_count_in;
  logic [20:0] frame_header_in;
  logic [39:0] anc_data_in, b;
  logic mute_active, output_clock_enable, request_pin, soft_reset_pulse;
  logic anc_capture_pulse, core_command_clear, header_no_crc, header_private;
  logic header_free_format, header_bitrate_bad, header_sampling_bad;
  logic header_padding, header_copyright, header_original, header_layer_ok;
  int fails, checked;
  audio_decoder_control_status_regs uut (.clk, .reset_n, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .crystal_input_clock,
    .data_request, .decoder_in_decode, .sync_state_in, .frame_locked,
    .frame_header_in, .frame_decoded_ok, .anc_bit_count_in, .anc_data_in,
    .play_active, .mute_active, .output_clock_enable, .request_pin,
    .soft_reset_pulse, .anc_capture_pulse, .core_command_clear,
    .header_version, .header_layer, .header_no_crc, .header_bitrate_index,
    .header_free_format, .header_bitrate_bad, .header_sampling_index,
    .header_sampling_bad, .header_padding, .header_private, .header_mode,
    .header_mode_ext, .header_copyright, .header_original, .header_emphasis,
    .header_layer_ok);
  host_model host (.clk, .reg_rdata, .reg_write, .reg_read, .reg_addr,
    .reg_wdata);
  // system clock and a crystal clock of four system periods
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    xdiv <= xdiv + 2'h1;
    crystal_input_clock <= xdiv[1];
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    cmp(d, e);
  endtask
  // decoded flags and fields, packed in header bit order
  function automatic logic [31:0] hdr();
    return {header_layer_ok, header_free_format, header_bitrate_bad,
      header_sampling_bad, header_version, header_layer, header_no_crc,
      header_bitrate_index, header_sampling_index, header_padding,
      header_private, header_mode, header_mode_ext, header_copyright,
      header_original, header_emphasis};
  endfunction
  task automatic hcheck(input logic [20:0] h, input logic [31:0] e);
    @(posedge clk);
    frame_header_in <= h;
    frame_locked <= 1'b1;
    @(posedge clk);
    frame_locked <= 1'b0;
    wt(2);
    cmp(hdr(), e);
  endtask
  task automatic t_reset_values;
    rc(8'h13, 8'h01);
    rc(8'h14, 8'h00);
    rc(8'h16, 8'h00);
    rc(8'h18, 8'h00);
    for (int i = 0; i < 6; i++) rc(8'h40 + 8'(i), 8'h00);
  endtask
  task automatic t_play_mute;
    wt(2);
    cmp(play_active, 1'b0);
    @(posedge clk);
    decoder_in_decode <= 1'b1;
    wt(3);
    cmp(play_active, 1'b1);
    host.wr(8'h13, 8'h00);
    wt(2);
    cmp({play_active, output_clock_enable}, 2'b00);
    host.wr(8'h14, 8'h01);
    wt(2);
    cmp({mute_active, output_clock_enable}, 2'b11);
  endtask
  task automatic t_pin_select;
    int n;
    logic p;
    n = 0;
    host.wr(8'h18, 8'hfb);
    rc(8'h18, 8'h00);
    for (int i = 0; i < 40; i++) begin
      p = request_pin;
      wt(1);
      n += int'(request_pin && !p);
    end
    cmp(n >= 9 && n <= 11, 1'b1);
    host.wr(8'h18, 8'h04);
    rc(8'h18, 8'h04);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      data_request <= ~i[0];
      wt(5);
      cmp(request_pin, !i[0]);
    end
  endtask
  task automatic t_capture;
    @(posedge clk);
    anc_data_in <= 40'h5d5c5b5a59;
    host.fetch(b);
    cmp(b[31:0], 32'h5c5b5a59);
    cmp(b[39:32], 8'h5d);
    @(posedge clk);
    anc_data_in <= 40'h0;
    host.wr(8'h16, 8'h00);
    rc(8'h59, 8'h59);
  endtask
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sync_state_in <= 2'(i);
      wt(3);
      rc(8'h40, (i < 3) ? 8'(i) : 8'h02);
    end
    @(posedge clk);
    anc_bit_count_in <= 16'hbeef;
    frame_decoded_ok <= 1'b1;
    @(posedge clk);
    frame_decoded_ok <= 1'b0;
    rc(8'h41, 8'hef);
    host.wr(8'h42, 8'h00);
    rc(8'h42, 8'hbe);
    hcheck(21'h1fa5c3, 32'h001fa5c3);
    rc(8'h43, 8'h1f);
    rc(8'h44, 8'ha5);
    host.wr(8'h45, 8'h00);
    rc(8'h45, 8'hc3);
    hcheck(21'h03f05a, 32'h0143f05a);
    hcheck(21'h120eb5, 32'h01b20e85);
  endtask
  task automatic t_soft_reset;
    host.wr(8'h16, 8'h05);
    host.wr(8'h10, 8'h01);
    rc(8'h13, 8'h01);
    rc(8'h14, 8'h00);
    rc(8'h16, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h40, 8'h00);
    host.wr(8'h7f, 8'h5a);
    rc(8'h7f, 8'h00);
  endtask
  // reset, scenarios, verdict
  initial begin
    {reset_n, data_request, decoder_in_decode, frame_locked} = 4'h0;
    {frame_decoded_ok, sync_state_in} = 3'h0;
    {frame_header_in, anc_bit_count_in, anc_data_in} = 77'h0;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_values;
    t_play_mute;
    t_pin_select;
    t_capture;
    t_status;
    t_soft_reset;
    finish_test;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test;
  end
endmodule
bind audio_decoder_control_status_regs audio_regs_checker chk (.clk,
  .reset_n, .reg_write, .reg_addr, .reg_wdata, .decoder_in_decode,
  .frame_locked, .frame_header_in, .play_active, .mute_active,
  .output_clock_enable, .soft_reset_pulse, .core_command_clear,
  .anc_capture_pulse, .header_version, .header_layer, .header_bitrate_index,
  .header_free_format, .header_sampling_index, .header_sampling_bad,
  .header_mode, .header_mode_ext, .header_layer_ok);
